// >>> src/usc_defs.svh
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH
// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define USC_AW 12
`define USC_OFS_MAIN_CTRL 12'h000
`define USC_OFS_FRAME_CTRL 12'h004
`define USC_OFS_MODE_CTRL 12'h008
`define USC_OFS_BAUD_DIV 12'h00C
`define USC_OFS_GUARD_PSC 12'h010
`define USC_OFS_RX_TMO 12'h014
`define USC_OFS_REQ_TRIG 12'h018
`define USC_OFS_INT_STAT 12'h01C
`define USC_OFS_FLAG_CLR 12'h020
`define USC_OFS_RX_VALUE 12'h024
`define USC_OFS_TX_VALUE 12'h028
// ****************************************************************
// Field positions
// ****************************************************************
`define USC_B_PARITY 0
`define USC_B_FRAMING 1
`define USC_B_NOISE 2
`define USC_B_OVERRUN 3
`define USC_B_IDLE 4
`define USC_B_RXFULL 5
`define USC_B_TXDONE 6
`define USC_B_TXEMPTY 7
`define USC_B_MUTE 19
`define USC_B_GUARD 25
`define USC_CR1_IDLE_LINE_IRQ_EN 4
`define USC_CR1_RXFULLIE 5
`define USC_CR1_TCIE 6
`define USC_CR1_TXEIE 7
`define USC_CR1_PARITY_IRQ_EN 8
`define USC_CR1_PS 9
`define USC_CR1_PCE 10
`define USC_CR1_M0 12
`define USC_CR1_MME 13
`define USC_CR1_M1 28
`define USC_CR3_EIE 0
`define USC_CR3_SCEN 5
`define USC_CR3_DMAR 6
`define USC_CR3_OVERRUN_DISABLE 12
`define USC_RQ_RXFLUSH 3
`define USC_RQ_W 5
`define USC_DATA_W 9
// ****************************************************************
// Reset values
// ****************************************************************
`define USC_RST_ZERO 32'h00000000
`endif

// >>> src/usc_pkg.sv
`default_nettype none
package usc_pkg;
	// Strobes from the receiver, transmitter and feature blocks
	typedef struct packed {
		logic rx_load;        // Character ready in input shift register
		logic idle_detect;    // Idle line seen
		logic noise_detect;   // Noise on received frame
		logic framing_detect; // Desync, excess noise or break
		logic parity_detect;  // Received parity mismatch
		logic sc_tx_exhausted;// Smartcard retries used up
		logic tx_load;        // Shifter took the transmit value
		logic tx_frame_done;  // Data frame finished on the line
		logic [6:0] aux_set;  // Guard, break, cts, timeout, block, match, wakeup
	} usc_evt_s;
	typedef logic [31:0] usc_word_t;
	// Status bit and clear bit of each auxiliary flag, same index as aux_set
	localparam int USC_AUX_POS [7] = '{25, 8, 9, 11, 12, 17, 20};
	localparam int USC_AUX_CLR [7] = '{7, 8, 9, 11, 12, 17, 20};
endpackage : usc_pkg
`default_nettype wire

// >>> src/usc_regs.sv
// Contract
// - Set receive-full when a character lands in receive value; interrupt if enabled.
// - Receive value read or flush request clears receive-full.
// - Set idle flag on idle detection; interrupt if enabled; clear bit clears it.
// - Idle flag is not set again until receive-full is set anew.
// - Muted receiver never sets the idle flag while mute operation is on.
// - New character while receive-full sets overrun; held value kept, shifter overwritten.
// - Overrun interrupts via receive-full or error enable; multibuffer uses error only.
// - Overrun-disable holds overrun flag at zero with no detection.
// - Noise sets noise flag; interrupt only in multibuffer with error enable.
// - Desync, excess noise or break sets framing flag; interrupts with error enable.
// - Smartcard transmit retries exhausted sets the framing flag.
// - Receive parity error sets parity flag; interrupt with parity enable.
// - Clear bits 3,2,1,0,6,4 clear overrun, noise, framing, parity, done, idle.
// - Clear bits 20,17,12,11,9,8,7 clear the auxiliary flags.
// - Without smartcard support the guard clear bit is reserved, forced zero.
// - Received character reads as 9-bit field, parity bit in top when enabled.
// - With parity on, written top character bit is replaced by computed parity.
// - Transmit-empty sets when shifter takes the value; transmit write clears it.
// - Transmit-complete sets at frame end with transmit-empty; clear bit or write clears.
//
// Added by the designer: register access over AHB-Lite.
`include "usc_defs.svh"
`default_nettype none
module usc_regs
	import usc_pkg::*;
#(
	parameter bit SMARTCARD_EN = 1'b1 // Smartcard feature present
) (
	input wire logic hclk,                  // Bus clock, 40 MHz
	input wire logic hresetn,               // Async reset, active low
	input wire logic hsel,                  // Slave select
	input wire logic [31:0] haddr,          // Byte address
	input wire logic [1:0] htrans,          // Transfer type
	input wire logic hwrite,                // Write when high
	input wire logic [2:0] hsize,           // Word only
	input wire logic [31:0] hwdata,         // Write data
	input wire logic hready,                // Bus ready
	output logic hreadyout,                 // Always ready
	output logic hresp,                     // Always OKAY
	output logic [31:0] hrdata,             // Read data
	input wire usc_evt_s evt,               // Strobes from the engines
	input wire logic [8:0] rx_char,         // Character in the input shifter
	input wire logic mute_state,            // Receiver muted
	output logic [8:0] tx_char,             // Character for the output shifter
	output logic tx_pending,                // Transmit value waiting
	output logic [`USC_RQ_W-1:0] req_pulse, // Request strobes to the engines
	output usc_word_t main_control,         // Control word 1
	output usc_word_t frame_control,        // Control word 2
	output usc_word_t mode_control,         // Control word 3
	output usc_word_t baud_divisor,         // Baud divisor
	output usc_word_t guard_prescaler,      // Guard time and prescaler
	output usc_word_t rx_timeout_block_len, // Timeout and block length
	output logic irq                        // Combined interrupt, active high
);
	// ****************************************************************
	// Bus address phase
	// ****************************************************************
	wire logic acc = hsel & htrans[1] & hready;
	wire logic [`USC_AW-1:0] aofs = haddr[`USC_AW-1:0];
	wire logic hit_hi = (haddr[31:`USC_AW] == '0);
	wire logic rd_acc = acc & ~hwrite;
	wire logic rd_rx = rd_acc & hit_hi & (aofs == `USC_OFS_RX_VALUE);

	logic wr_pend_ff;
	logic [`USC_AW-1:0] wr_ofs_ff;
	logic wr_hi_ff;

	// Writes are captured in the address phase and applied with hwdata
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_ofs_ff <= '0;
			wr_hi_ff <= 1'b0;
		end else begin
			wr_pend_ff <= acc & hwrite;
			wr_ofs_ff <= aofs;
			wr_hi_ff <= hit_hi;
		end
	end

	// Data-phase write strobes per register
	wire logic wr_ok = wr_pend_ff & wr_hi_ff;
	wire logic wr_cr1 = wr_ok & (wr_ofs_ff == `USC_OFS_MAIN_CTRL);
	wire logic wr_cr2 = wr_ok & (wr_ofs_ff == `USC_OFS_FRAME_CTRL);
	wire logic wr_cr3 = wr_ok & (wr_ofs_ff == `USC_OFS_MODE_CTRL);
	wire logic wr_brr = wr_ok & (wr_ofs_ff == `USC_OFS_BAUD_DIV);
	wire logic wr_gtp = wr_ok & (wr_ofs_ff == `USC_OFS_GUARD_PSC);
	wire logic wr_rto = wr_ok & (wr_ofs_ff == `USC_OFS_RX_TMO);
	wire logic wr_rqr = wr_ok & (wr_ofs_ff == `USC_OFS_REQ_TRIG);
	wire logic wr_icr = wr_ok & (wr_ofs_ff == `USC_OFS_FLAG_CLR);
	wire logic wr_tdr = wr_ok & (wr_ofs_ff == `USC_OFS_TX_VALUE);

	// ****************************************************************
	// Control registers
	// ****************************************************************
	usc_word_t cr1_ff, cr2_ff, cr3_ff, brr_ff, gtp_ff, rto_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cr1_ff <= `USC_RST_ZERO;
			cr2_ff <= `USC_RST_ZERO;
			cr3_ff <= `USC_RST_ZERO;
			brr_ff <= `USC_RST_ZERO;
			gtp_ff <= `USC_RST_ZERO;
			rto_ff <= `USC_RST_ZERO;
		end else begin
			if (wr_cr1) cr1_ff <= hwdata;
			if (wr_cr2) cr2_ff <= hwdata;
			if (wr_cr3) cr3_ff <= hwdata;
			if (wr_brr) brr_ff <= hwdata;
			if (wr_gtp) gtp_ff <= hwdata;
			if (wr_rto) rto_ff <= hwdata;
		end
	end

	// Named control bits
	wire logic idle_ie = cr1_ff[`USC_CR1_IDLE_LINE_IRQ_EN];
	wire logic rxfull_ie = cr1_ff[`USC_CR1_RXFULLIE];
	wire logic tc_ie = cr1_ff[`USC_CR1_TCIE];
	wire logic txe_ie = cr1_ff[`USC_CR1_TXEIE];
	wire logic par_ie = cr1_ff[`USC_CR1_PARITY_IRQ_EN];
	wire logic par_odd = cr1_ff[`USC_CR1_PS];
	wire logic parity_enable = cr1_ff[`USC_CR1_PCE];
	wire logic mute_enable = cr1_ff[`USC_CR1_MME];
	wire logic [1:0] wlen = {cr1_ff[`USC_CR1_M1], cr1_ff[`USC_CR1_M0]};
	wire logic err_ie = cr3_ff[`USC_CR3_EIE];
	wire logic sc_on = cr3_ff[`USC_CR3_SCEN];
	wire logic multibuf = cr3_ff[`USC_CR3_DMAR];
	wire logic overrun_disable = cr3_ff[`USC_CR3_OVERRUN_DISABLE];

	// Flag clear and request strobes; zero bits have no effect
	wire logic [31:0] clr = wr_icr ? hwdata : 32'h00000000;
	wire logic rx_flush_request = wr_rqr & hwdata[`USC_RQ_RXFLUSH];

	// ****************************************************************
	// Receive side flags
	// ****************************************************************
	logic rxfull_ff, idle_ff, idle_arm_ff, ovr_ff, noise_ff, frm_ff, par_ff;
	logic [8:0] rdr_ff;

	// A read in the same cycle frees the holding register for the new character
	wire logic rx_room = ~rxfull_ff | rd_rx;
	wire logic rdr_load = evt.rx_load & (rx_room | overrun_disable);
	wire logic ovr_set = evt.rx_load & ~rx_room & ~overrun_disable;
	wire logic idle_set = evt.idle_detect & idle_arm_ff
		& ~(mute_enable & mute_state);
	wire logic frm_set = evt.framing_detect
		| (evt.sc_tx_exhausted & sc_on);

	// Next values: set wins over clear in every flag
	wire logic nxt_rxfull = (rxfull_ff & ~rd_rx & ~rx_flush_request)
		| evt.rx_load;
	wire logic nxt_idle = (idle_ff & ~clr[`USC_B_IDLE]) | idle_set;
	wire logic nxt_idle_arm = (idle_arm_ff & ~idle_set) | evt.rx_load;
	wire logic nxt_ovr = overrun_disable ? 1'b0
		: (ovr_ff & ~clr[`USC_B_OVERRUN]) | ovr_set;
	wire logic nxt_noise = (noise_ff & ~clr[`USC_B_NOISE]) | evt.noise_detect;
	wire logic nxt_frm = (frm_ff & ~clr[`USC_B_FRAMING]) | frm_set;
	wire logic nxt_par = (par_ff & ~clr[`USC_B_PARITY]) | evt.parity_detect;

	// Receive flag and holding register state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxfull_ff <= 1'b0;
			idle_ff <= 1'b0;
			idle_arm_ff <= 1'b1;
			ovr_ff <= 1'b0;
			noise_ff <= 1'b0;
			frm_ff <= 1'b0;
			par_ff <= 1'b0;
			rdr_ff <= '0;
		end else begin
			rxfull_ff <= nxt_rxfull;
			idle_ff <= nxt_idle;
			idle_arm_ff <= nxt_idle_arm;
			ovr_ff <= nxt_ovr;
			noise_ff <= nxt_noise;
			frm_ff <= nxt_frm;
			par_ff <= nxt_par;
			if (rdr_load) rdr_ff <= rx_char;
		end
	end

	// ****************************************************************
	// Transmit side flags and parity insertion
	// ****************************************************************
	logic txe_ff, tc_ff;
	logic [8:0] tdr_ff;

	wire logic nxt_txe = (txe_ff & ~wr_tdr) | evt.tx_load;
	wire logic tc_set = evt.tx_frame_done & txe_ff;
	wire logic nxt_tc = (tc_ff & ~clr[`USC_B_TXDONE] & ~wr_tdr) | tc_set;

	// Parity over the data bits below the parity position of each word length
	wire logic [8:0] dmask = (wlen == 2'b01) ? 9'h0FF : (wlen == 2'b10) ? 9'h03F : 9'h07F;
	wire logic par_bit = (^(tdr_ff & dmask)) ^ par_odd;
	wire logic [8:0] pmask = (wlen == 2'b01) ? 9'h100 : (wlen == 2'b10) ? 9'h040 : 9'h080;
	wire logic [8:0] nxt_tx_char = parity_enable
		? ((tdr_ff & ~pmask) | (par_bit ? pmask : 9'h000)) : tdr_ff;

	// Transmit state; reset leaves the holding register empty and the line done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txe_ff <= 1'b1;
			tc_ff <= 1'b1;
			tdr_ff <= '0;
			tx_char <= '0;
			tx_pending <= 1'b0;
		end else begin
			txe_ff <= nxt_txe;
			tc_ff <= nxt_tc;
			if (wr_tdr) tdr_ff <= hwdata[`USC_DATA_W-1:0];
			tx_char <= nxt_tx_char;
			tx_pending <= ~nxt_txe;
		end
	end

	// ****************************************************************
	// Auxiliary sticky flags set by the feature engines
	// ****************************************************************
	logic [6:0] aux_ff;

	// One set-wins flag per entry; the guard flag vanishes without smartcard
	for (genvar i = 0; i < 7; i++) begin : g_aux
		localparam bit ABSENT = (i == 0) && !SMARTCARD_EN;
		wire logic aux_clr = ABSENT ? 1'b0 : clr[USC_AUX_CLR[i]];
		wire logic nxt_aux = ABSENT ? 1'b0 : ((aux_ff[i] & ~aux_clr) | evt.aux_set[i]);
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				aux_ff[i] <= 1'b0;
			end else begin
				aux_ff[i] <= nxt_aux;
			end
		end
	end

	// ****************************************************************
	// Status word, read mux and bus answer
	// ****************************************************************
	usc_word_t isr;
	always_comb begin
		isr = '0;
		isr[`USC_B_PARITY] = par_ff;
		isr[`USC_B_FRAMING] = frm_ff;
		isr[`USC_B_NOISE] = noise_ff;
		isr[`USC_B_OVERRUN] = ovr_ff;
		isr[`USC_B_IDLE] = idle_ff;
		isr[`USC_B_RXFULL] = rxfull_ff;
		isr[`USC_B_TXDONE] = tc_ff;
		isr[`USC_B_TXEMPTY] = txe_ff;
		isr[`USC_B_MUTE] = mute_state;
		for (int k = 0; k < 7; k++) begin
			isr[USC_AUX_POS[k]] = aux_ff[k];
		end
	end

	// Clear and request registers read as zero, as do unmapped words
	wire usc_word_t rd_mux =
		!hit_hi ? 32'h00000000 :
		(aofs == `USC_OFS_MAIN_CTRL) ? cr1_ff :
		(aofs == `USC_OFS_FRAME_CTRL) ? cr2_ff :
		(aofs == `USC_OFS_MODE_CTRL) ? cr3_ff :
		(aofs == `USC_OFS_BAUD_DIV) ? brr_ff :
		(aofs == `USC_OFS_GUARD_PSC) ? gtp_ff :
		(aofs == `USC_OFS_RX_TMO) ? rto_ff :
		(aofs == `USC_OFS_INT_STAT) ? isr :
		(aofs == `USC_OFS_RX_VALUE) ? {23'h000000, rdr_ff} :
		(aofs == `USC_OFS_TX_VALUE) ? {23'h000000, tdr_ff} :
		32'h00000000;

	// Interrupt sources; overrun routing depends on multibuffer mode
	wire logic ovr_irq = ovr_ff & (multibuf ? err_ie : (rxfull_ie | err_ie));
	wire logic nxt_irq = (rxfull_ff & rxfull_ie)
		| (idle_ff & idle_ie)
		| ovr_irq
		| (noise_ff & multibuf & err_ie)
		| (frm_ff & err_ie)
		| (par_ff & par_ie)
		| (txe_ff & txe_ie)
		| (tc_ff & tc_ie);

	// Registered outputs; zero wait states so the answer is one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= 1'b0;
			req_pulse <= '0;
		end else begin
			if (rd_acc) hrdata <= rd_mux;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			irq <= nxt_irq;
			req_pulse <= wr_rqr ? hwdata[`USC_RQ_W-1:0] : '0;
		end
	end

	// Control words go out to the engines straight from their flops
	assign main_control = cr1_ff;
	assign frame_control = cr2_ff;
	assign mode_control = cr3_ff;
	assign baud_divisor = brr_ff;
	assign guard_prescaler = gtp_ff;
	assign rx_timeout_block_len = rto_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_rx_into_empty;
		evt.rx_load && !rxfull_ff;
	endsequence
	sequence s_full_after;
		rxfull_ff && rdr_ff == $past(rx_char);
	endsequence

	rx_full_set_a: assert property (s_rx_into_empty |=> s_full_after)
		else $error("receive-full or value not loaded");
	rx_read_clr_a: assert property (rd_rx && !evt.rx_load |=> !rxfull_ff)
		else $error("receive-full not cleared by read");
	idle_rearm_a: assert property ((idle_set |=> !idle_arm_ff)
		and (!idle_arm_ff && !idle_ff |=> !idle_ff))
		else $error("idle flag re-armed early");
	idle_mute_a: assert property (mute_enable && mute_state && !idle_ff |=> !idle_ff)
		else $error("idle flag set while muted");
	ovr_keep_a: assert property (ovr_set |=> ovr_ff && $stable(rdr_ff))
		else $error("overrun lost or value overwritten");
	ovr_irq_a: assert property (ovr_ff && multibuf && !err_ie && !rxfull_ie && !tc_ie
		&& !txe_ie && !par_ie && !idle_ie |=> !irq)
		else $error("overrun interrupt without error enable");
	ovr_off_a: assert property (overrun_disable |=> !ovr_ff)
		else $error("overrun flag under disable");
	frm_irq_a: assert property (frm_ff && err_ie |=> irq)
		else $error("framing interrupt missing");
	clr_set_win_a: assert property (clr[`USC_B_PARITY] && evt.parity_detect |=> par_ff)
		else $error("parity set lost to clear");
	tc_clear_a: assert property (wr_tdr && !tc_set && !evt.tx_load |=> !tc_ff && !txe_ff)
		else $error("transmit write did not clear flags");
	tx_parity_a: assert property (parity_enable && wlen == 2'b00
		|=> tx_char[7] == ((^($past(tdr_ff) & 9'h07F)) ^ $past(par_odd)))
		else $error("parity bit not inserted");
endmodule : usc_regs
`default_nettype wire

// >>> tb/usc_far_end.sv
`default_nettype none
module usc_far_end
	import usc_pkg::*;
(
	input wire logic hclk,          // Bus clock
	input wire logic [8:0] tx_char, // Character offered to the output shifter
	output var usc_evt_s evt,       // Strobes from receiver and transmitter engines
	output logic [8:0] rx_char,     // Character in the input shifter
	output logic mute_state         // Receiver muted
);
	// ****************************************************************
	// Serial side stand-in
	// ****************************************************************
	logic [8:0] shifted;
	// Quiet engines at time zero
	initial begin
		evt = '0;
		rx_char = 9'h000;
		mute_state = 1'b0;
		shifted = 9'h000;
	end
	// Output shifter takes the offered character on its load strobe
	always @(posedge hclk) begin
		if (evt.tx_load) begin
			shifted <= tx_char;
		end
	end
	// One-cycle strobe; the shifter value is only meaningful with it
	task automatic strobe(input usc_evt_s e, input logic [8:0] ch);
		@(posedge hclk);
		evt <= e;
		rx_char <= ch;
		@(posedge hclk);
		evt <= '0;
		rx_char <= ~ch; // Stale character is not shown between loads
	endtask : strobe
	// Mute is a level held by the receiver engine
	task automatic mute(input logic m);
		@(posedge hclk);
		mute_state <= m;
	endtask : mute
endmodule : usc_far_end
`default_nettype wire

// >>> tb/usc_regs_tb_top.sv
`include "usc_defs.svh"
`default_nettype none
module usc_regs_tb_top
	import usc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	typedef struct {int k; logic [31:0] cr1, cr3, flag, clr; logic ir;} usc_row_s;
	localparam logic [31:0] BASE = 32'h000000C0; // Transmit-empty and complete after reset
	localparam int E_RX = 14;
	localparam int E_IDLE = 13;
	localparam int E_PAR = 10;
	localparam int E_TXLD = 8;
	localparam int E_TXDN = 7;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, mute_state, tx_pending, irq;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [8:0] rx_char, tx_char;
	logic [`USC_RQ_W-1:0] req_pulse;
	usc_word_t cr1_q, cr2_q, cr3_q, baud_q, gt_q, rto_q;
	usc_evt_s evt;
	int n_mismatch = 0;
	int n_tests = 0;
	// Event, enables, flag seen, clear bit, interrupt expected
	usc_row_s rows [13] = '{
		'{10, 32'h00000100, 32'h00000000, 32'h00000001, 32'h00000001, 1'b1},
		'{11, 32'h00000000, 32'h00000001, 32'h00000002, 32'h00000002, 1'b1},
		'{12, 32'h00000000, 32'h00000001, 32'h00000004, 32'h00000004, 1'b0},
		'{12, 32'h00000000, 32'h00000041, 32'h00000004, 32'h00000004, 1'b1},
		'{9, 32'h00000000, 32'h00000021, 32'h00000002, 32'h00000002, 1'b1},
		'{13, 32'h00000010, 32'h00000000, 32'h00000010, 32'h00000010, 1'b1},
		'{0, 32'h00000000, 32'h00000000, 32'h02000000, 32'h00000080, 1'b0},
		'{1, 32'h00000000, 32'h00000000, 32'h00000100, 32'h00000100, 1'b0},
		'{2, 32'h00000000, 32'h00000000, 32'h00000200, 32'h00000200, 1'b0},
		'{3, 32'h00000000, 32'h00000000, 32'h00000800, 32'h00000800, 1'b0},
		'{4, 32'h00000000, 32'h00000000, 32'h00001000, 32'h00001000, 1'b0},
		'{5, 32'h00000000, 32'h00000000, 32'h00020000, 32'h00020000, 1'b0},
		'{6, 32'h00000000, 32'h00000000, 32'h00100000, 32'h00100000, 1'b0}};
	assign hready = hreadyout; // The only slave drives the bus ready
	usc_regs #(.SMARTCARD_EN(1'b1)) u_usc_regs (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt),
		.rx_char(rx_char), .mute_state(mute_state), .tx_char(tx_char),
		.tx_pending(tx_pending), .req_pulse(req_pulse), .main_control(cr1_q),
		.frame_control(cr2_q), .mode_control(cr3_q), .baud_divisor(baud_q),
		.guard_prescaler(gt_q), .rx_timeout_block_len(rto_q), .irq(irq));
	usc_far_end u_usc_far_end (.hclk(hclk), .tx_char(tx_char), .evt(evt),
		.rx_char(rx_char), .mute_state(mute_state));
	// ****************************************************************
	// Bus and check tasks
	// ****************************************************************
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t got=%08h exp=%08h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	// Address phase held until ready, then data phase held until ready
	task automatic bus(input logic w, input logic [11:0] ofs, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {20'h00000, ofs};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rdv = hrdata;
	endtask : bus
	task automatic wr(input logic [11:0] ofs, input logic [31:0] wd);
		bus(1'b1, ofs, wd);
	endtask : wr
	task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
		bus(1'b0, ofs, 32'h00000000);
		chk(rdv, exp);
	endtask : rd
	function automatic usc_evt_s ev(input int k);
		ev = '0;
		ev[k] = 1'b1;
	endfunction : ev
	task automatic hit(input int k, input logic [8:0] ch);
		u_usc_far_end.strobe(ev(k), ch);
	endtask : hit
	task automatic wrap_up();
		$display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// Whole run needs well under this many cycles
	initial begin
		repeat (6000) @(posedge hclk);
		n_mismatch++;
		$display("FAIL t=%0t watchdog got=%08h exp=%08h", $time, 32'h0, 32'h1);
		wrap_up();
	end
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
		cyc(3);
		hresetn <= 1'b1;
		cyc(1);
		foreach (rows[i]) begin
			wr(`USC_OFS_MAIN_CTRL, rows[i].cr1);
			wr(`USC_OFS_MODE_CTRL, rows[i].cr3);
			hit(rows[i].k, 9'h000);
			cyc(3);
			chk({31'h0, irq}, {31'h0, rows[i].ir});
			wr(`USC_OFS_FLAG_CLR, 32'h00000000);
			rd(`USC_OFS_INT_STAT, BASE | rows[i].flag);
			wr(`USC_OFS_FLAG_CLR, rows[i].clr);
			rd(`USC_OFS_INT_STAT, BASE);
		end
		$display("test flag table done");
		wr(`USC_OFS_BAUD_DIV, 32'h0000ABCD);
		cyc(1);
		chk(baud_q, 32'h0000ABCD);
		hresetn <= 1'b0;
		cyc(3);
		hresetn <= 1'b1;
		cyc(1);
		chk(baud_q | cr1_q | cr2_q | cr3_q | gt_q | rto_q, 32'h0);
		chk({22'h0, hresp, tx_pending, tx_char}, 32'h0);
		for (int a = 0; a <= 44; a += 4) rd(12'(a), (a == 28) ? BASE : 32'h0);
		rd(12'h100, 32'h00000000);
		$display("test reset values done");
		hit(E_IDLE, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE | 32'h10);
		wr(`USC_OFS_FLAG_CLR, 32'h00000010);
		hit(E_IDLE, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE);
		hit(E_RX, 9'h000);
		rd(`USC_OFS_RX_VALUE, 32'h00000000);
		hit(E_IDLE, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE | 32'h10);
		wr(`USC_OFS_FLAG_CLR, 32'h00000010);
		wr(`USC_OFS_MAIN_CTRL, 32'h00002000);
		u_usc_far_end.mute(1'b1);
		hit(E_RX, 9'h000);
		rd(`USC_OFS_RX_VALUE, 32'h00000000);
		hit(E_IDLE, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE | 32'h00080000);
		u_usc_far_end.mute(1'b0);
		hit(E_IDLE, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE | 32'h10);
		wr(`USC_OFS_FLAG_CLR, 32'h00000010);
		$display("test idle and mute done");
		wr(`USC_OFS_MAIN_CTRL, 32'h00001420);
		hit(E_RX, 9'h1A5);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		hit(E_RX, 9'h05A);
		rd(`USC_OFS_INT_STAT, BASE | 32'h28);
		wr(`USC_OFS_MAIN_CTRL, 32'h00001400);
		wr(`USC_OFS_MODE_CTRL, 32'h00000001);
		rd(`USC_OFS_RX_VALUE, 32'h000001A5);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		rd(`USC_OFS_INT_STAT, BASE | 32'h08);
		wr(`USC_OFS_FLAG_CLR, 32'h00000008);
		wr(`USC_OFS_MODE_CTRL, 32'h00001000);
		hit(E_RX, 9'h011);
		hit(E_RX, 9'h022);
		rd(`USC_OFS_INT_STAT, BASE | 32'h20);
		rd(`USC_OFS_RX_VALUE, 32'h00000022);
		hit(E_RX, 9'h033);
		wr(`USC_OFS_REQ_TRIG, 32'h00000008);
		@(negedge hclk);
		chk({27'h0, req_pulse}, 32'h00000008);
		@(posedge hclk);
		rd(`USC_OFS_INT_STAT, BASE);
		$display("test receive done");
		hit(E_PAR, 9'h000);
		fork
			wr(`USC_OFS_FLAG_CLR, 32'h00000001);
			hit(E_PAR, 9'h000);
		join
		rd(`USC_OFS_INT_STAT, BASE | 32'h01);
		wr(`USC_OFS_FLAG_CLR, 32'h00000001);
		$display("test set over clear done");
		wr(`USC_OFS_MAIN_CTRL, 32'h00000400);
		rd(`USC_OFS_INT_STAT, BASE);
		wr(`USC_OFS_TX_VALUE, 32'h000000FE);
		rd(`USC_OFS_INT_STAT, 32'h00000000);
		chk({31'h0, tx_pending}, 32'h1);
		hit(E_TXDN, 9'h000);
		rd(`USC_OFS_INT_STAT, 32'h00000000);
		hit(E_TXLD, 9'h000);
		cyc(1);
		chk({24'h0, u_usc_far_end.shifted[7:0]}, 32'h7E);
		rd(`USC_OFS_INT_STAT, 32'h00000080);
		hit(E_TXDN, 9'h000);
		rd(`USC_OFS_INT_STAT, BASE);
		wr(`USC_OFS_FLAG_CLR, 32'h00000040);
		rd(`USC_OFS_INT_STAT, 32'h00000080);
		wr(`USC_OFS_MAIN_CTRL, 32'h00000600);
		wr(`USC_OFS_TX_VALUE, 32'h0000007E);
		hit(E_TXLD, 9'h000);
		cyc(1);
		chk({24'h0, u_usc_far_end.shifted[7:0]}, 32'hFE);
		$display("test transmit done");
		wrap_up();
	end
endmodule : usc_regs_tb_top
`default_nettype wire
